// ### pkg/irq_arm_regs.vh
`ifndef IRQ_ARM_REGS_VH
`define IRQ_ARM_REGS_VH

// Register byte offsets
`define ENABLE_OFS      12'h000
`define ARM_SET_OFS     12'h004
`define DISARM_OFS      12'h008
`define STATUS_OFS      12'h00C
`define MASK_OFS        12'h010
`define ARMED_OFS       12'h014

// Field positions
`define CH2_BIT         2
`define CH3_BIT         3
`define ERR_BIT         4
`define FIELD_LSB       2
`define FIELD_MSB       4

// Reset values
`define ENABLE_RST      3'h0
`define ARM_RST         3'h0
`define STATUS_RST      3'h0
`define MASK_RST        3'h0

`endif

// ### hw/irq_arm_set_logic.v
// Decided for this implementation: the register offsets and the APB interface to the registers.
`include "irq_arm_regs.vh"

// Summary of operation
// R1 - Bit 4 arms error interrupt on write one when error enable is set.
// R2 - Error arm bit ignores writes and stays zero while error enable is zero.
// R3 - Writing zero to any arm bit has no effect.
// R4 - A set arm bit stays one until explicitly disarmed; here clearing its enable bit also clears it.
// R5 - Writing one to error disarm bit clears error arm bit.
// R6 - Bit 3 arms channel 3 frame interrupt only while its enable is one.
// R7 - Channel 3 arm bit ignores writes and stays zero without enable.
// R8 - Writing one to channel 3 disarm bit clears channel 3 arm bit.
// R9 - Bit 2 arms channel 2 frame interrupt only while its enable is one.
// R10 - Channel 2 arm bit ignores writes and stays zero without enable.
// R11 - Writing one to channel 2 disarm bit clears channel 2 arm bit.
// R12 - Software sets the enable bit before writing the arm bit.
// R13 - Error interrupt raised on any port byte stream error.
// R14 - Each channel frame interrupt is one pulse per video frame.
// R15 - Events forwarded only with enable and arm set; bits 31..5 read zero.
module irq_arm_set_logic (
  // Clock, reset, enable
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        clk_en,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Event inputs from port logic
  input  wire        stream_error,
  input  wire        chan3_frame_pulse,
  input  wire        chan2_frame_pulse,
  // Interrupt outputs
  output reg         port_error_irq,
  output reg         chan3_frame_irq,
  output reg         chan2_frame_irq,
  output wire        irq
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  // Source index inside the three-bit field
  localparam        SRC_CH2    = 0;
  localparam        SRC_CH3    = 1;
  localparam        SRC_ERR    = 2;
  localparam        NSRC       = 3;
  localparam [2:0]  FIELD_ZERO = 3'h0;
  localparam [31:0] WORD_ZERO  = 32'h00000000;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // True for any offset that has a register behind it
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `ENABLE_OFS) |
               (a == `ARM_SET_OFS) |
               (a == `DISARM_OFS) |
               (a == `STATUS_OFS) |
               (a == `MASK_OFS) |
               (a == `ARMED_OFS);
    end
  endfunction

  // Strobe for one register offset
  function hit;
    input        strobe;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = strobe & (a == ofs);
    end
  endfunction

  // Field at bits 4:2 of a word, all other bits zero
  function [31:0] place;
    input [2:0] f;
    begin
      place = WORD_ZERO;
      place[`FIELD_MSB:`FIELD_LSB] = f;
    end
  endfunction

  // Field qualified by a write strobe
  function [2:0] gated;
    input       strobe;
    input [2:0] f;
    begin
      if (strobe) begin
        gated = f;
      end else begin
        gated = FIELD_ZERO;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Zero wait states: every access ends in its first access cycle
  wire        acc;
  wire        wr;
  wire        rd_setup;
  wire [2:0]  wfield;
  wire        wr_en;
  wire        wr_set;
  wire        wr_clr;
  wire        wr_stat;
  wire        wr_mask;

  assign acc      = psel & penable & clk_en;
  assign wr       = acc & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite & clk_en;
  assign wfield   = pwdata[`FIELD_MSB:`FIELD_LSB];
  assign wr_en    = hit(wr, paddr, `ENABLE_OFS);
  assign wr_set   = hit(wr, paddr, `ARM_SET_OFS);
  assign wr_clr   = hit(wr, paddr, `DISARM_OFS);
  assign wr_stat  = hit(wr, paddr, `STATUS_OFS);
  assign wr_mask  = hit(wr, paddr, `MASK_OFS);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Bits 2:0 map to error, channel 3, channel 2
  reg  [2:0] irq_enable_reg_r;
  reg  [2:0] irq_arm_set_r;
  wire [2:0] irq_arm_set_nxt;
  reg  [2:0] mask_r;
  wire [2:0] arm_set_req;
  wire [2:0] disarm_req;

  assign arm_set_req = gated(wr_set, wfield);
  assign disarm_req  = gated(wr_clr, wfield);

  always @(posedge clock) begin
    if (sys_rst) begin
      irq_enable_reg_r <= `ENABLE_RST;
    end else if (clk_en && wr_en) begin
      irq_enable_reg_r <= wfield;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      mask_r <= `MASK_RST;
    end else if (clk_en && wr_mask) begin
      mask_r <= wfield;
    end
  end

  // ----------------------------------------------------------------
  // Arm bits
  // ----------------------------------------------------------------
  // Enable gates both set and hold, so a dropped enable disarms
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_arm
      wire en_bit;
      wire arm_bit;
      wire kill;
      wire take;
      assign en_bit  = irq_enable_reg_r[g];
      assign arm_bit = irq_arm_set_r[g];
      // Disarm acts only on a bit that is armed
      assign kill    = disarm_req[g] & arm_bit; // R5 R8 R11
      // Only a written one arms; a zero leaves the bit alone
      assign take    = arm_set_req[g]; // R1 R6 R9 R3
      assign irq_arm_set_nxt[g] = ~en_bit ? 1'b0 : // R2 R7 R10
                                  kill    ? 1'b0 :
                                  take    ? 1'b1 :
                                  arm_bit; // R4
    end
  endgenerate

  always @(posedge clock) begin
    if (sys_rst) begin
      irq_arm_set_r <= `ARM_RST;
    end else if (clk_en) begin
      irq_arm_set_r <= irq_arm_set_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Event synchronisers
  // ----------------------------------------------------------------
  // Events come from port logic outside this clock
  reg  [2:0] ev_s1_r;
  reg  [2:0] ev_s2_r;
  reg  [2:0] ev_prev_r;
  wire [2:0] ev_raw;

  assign ev_raw[SRC_ERR] = stream_error;
  assign ev_raw[SRC_CH3] = chan3_frame_pulse;
  assign ev_raw[SRC_CH2] = chan2_frame_pulse;

  always @(posedge clock) begin
    if (sys_rst) begin
      ev_s1_r <= FIELD_ZERO;
      ev_s2_r <= FIELD_ZERO;
    end else if (clk_en) begin
      ev_s1_r <= ev_raw;
      ev_s2_r <= ev_s1_r;
    end
  end

  // History starts at the idle level so reset makes no false edge
  always @(posedge clock) begin
    if (sys_rst) begin
      ev_prev_r <= FIELD_ZERO;
    end else if (clk_en) begin
      ev_prev_r <= ev_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  wire [2:0] ev_rise;
  wire [2:0] live;
  wire [2:0] fire;

  generate
    for (g = 0; g < NSRC; g = g + 1) begin : g_evt
      assign ev_rise[g] = ev_s2_r[g] & ~ev_prev_r[g];
      assign live[g]    = irq_enable_reg_r[g] & irq_arm_set_r[g]; // R15
      assign fire[g]    = ev_rise[g] & live[g]; // R15
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status and interrupt outputs
  // ----------------------------------------------------------------
  reg  [2:0] status_r;
  wire [2:0] status_clr;
  wire [2:0] status_nxt;

  assign status_clr = gated(wr_stat, wfield);
  // Set wins over write-one-to-clear, so no event is lost
  assign status_nxt = (status_r & ~status_clr) | fire;

  always @(posedge clock) begin
    if (sys_rst) begin
      status_r <= `STATUS_RST;
    end else if (clk_en) begin
      status_r <= status_nxt;
    end
  end

  // Error line is a level while an error persists
  always @(posedge clock) begin
    if (sys_rst) begin
      port_error_irq <= 1'b0;
    end else if (clk_en) begin
      port_error_irq <= ev_s2_r[SRC_ERR] & live[SRC_ERR]; // R13
    end
  end

  // One pulse per frame edge
  always @(posedge clock) begin
    if (sys_rst) begin
      chan3_frame_irq <= 1'b0;
      chan2_frame_irq <= 1'b0;
    end else if (clk_en) begin
      chan3_frame_irq <= fire[SRC_CH3]; // R14
      chan2_frame_irq <= fire[SRC_CH2]; // R14
    end
  end

  assign irq = |(status_r & mask_r);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Loaded in the setup cycle so the data stand through the access
  reg [31:0] rd_word;

  always @* begin
    rd_word = WORD_ZERO; // R15
    case (paddr)
      `ENABLE_OFS: begin
        rd_word = place(irq_enable_reg_r);
      end
      `ARM_SET_OFS: begin
        rd_word = place(irq_arm_set_r);
      end
      `STATUS_OFS: begin
        rd_word = place(status_r);
      end
      `MASK_OFS: begin
        rd_word = place(mask_r);
      end
      `ARMED_OFS: begin
        rd_word = place(live);
      end
      default: begin
        rd_word = WORD_ZERO;
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      prdata <= WORD_ZERO;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end

endmodule

// ### verif/irq_arm_props.sv
module irq_arm_props (
  input wire        clock, sys_rst, psel, penable, pwrite, pslverr,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        stream_error, chan3_frame_pulse, chan2_frame_pulse,
  input wire        port_error_irq, chan3_frame_irq, chan2_frame_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable;
  // ----------------------------------------
  // Reads, refusals, event paths
  // ----------------------------------------
  property p_hi; acc && !pwrite && !pslverr |-> prdata[31:5] == 0; endproperty
  a_hi: assert property (p_hi) else $error("high bits set");
  property p_lo; acc && !pwrite && !pslverr |-> prdata[1:0] == 0; endproperty
  a_lo: assert property (p_lo) else $error("low bits set");
  property p_dis; acc && !pwrite && paddr == 12'h008 |-> prdata == 0;
  endproperty
  a_dis: assert property (p_dis) else $error("disarm read nonzero");
  property p_bad; acc && paddr > 12'h014 |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("no slave error");
  property p_c3; chan3_frame_irq |=> !chan3_frame_irq; endproperty
  a_c3: assert property (p_c3) else $error("ch3 pulse long");
  property p_c2; chan2_frame_irq |=> !chan2_frame_irq; endproperty
  a_c2: assert property (p_c2) else $error("ch2 pulse long");
  // Sync delay window, 2 to 4 edges back
  property p_e; port_error_irq |-> $past(stream_error, 2) ||
    $past(stream_error, 3) || $past(stream_error, 4); endproperty
  a_e: assert property (p_e) else $error("error irq uncaused");
  property p_s3; chan3_frame_irq |-> $past(chan3_frame_pulse, 2) ||
    $past(chan3_frame_pulse, 3) || $past(chan3_frame_pulse, 4); endproperty
  a_s3: assert property (p_s3) else $error("ch3 irq uncaused");
endmodule

// ### verif/testbench.sv
`include "irq_arm_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, sys_rst = 1, clk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, stream_error = 0, chan3_frame_pulse = 0;
  logic chan2_frame_pulse = 0, pready, pslverr, port_error_irq, irq;
  logic chan3_frame_irq, chan2_frame_irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rv, q[$];
  int errors = 0, cmp_count = 0, c3_n = 0, c2_n = 0;
  // Frame pulses counted on the edge, one per frame expected
  always @(posedge clock) begin
    c3_n += chan3_frame_irq;
    c2_n += chan2_frame_irq;
  end
  always #50 clock = ~clock;
  irq_arm_set_logic irq_arm_set_logic_i (.clock, .sys_rst, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .stream_error, .chan3_frame_pulse, .chan2_frame_pulse,
    .port_error_irq, .chan3_frame_irq, .chan2_frame_irq, .irq);
  task automatic ck(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Read data taken at the edge that completes the access
  always @(posedge clock)
    if (psel && penable && !pwrite && pready) ck("prdata", q.pop_front(), prdata);
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e);
    q.push_back(e);
    bus(0, a, 0);
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    conclude;
  end
  initial begin
    rv = $urandom(32'h644BFC40);
    repeat (12) @(posedge clock);
    sys_rst <= 0;
    bus(1, `ARM_SET_OFS, 32'h1C);
    rd(`ARM_SET_OFS, 0);
    bus(1, `ENABLE_OFS, 32'h1C);
    rv = $urandom;
    bus(1, `ARM_SET_OFS, rv);
    rd(`ARM_SET_OFS, rv & 32'h1C);
    bus(1, `ARM_SET_OFS, 0);
    rd(`ARM_SET_OFS, rv & 32'h1C);
    bus(1, `ARM_SET_OFS, 32'hFFFFFFFF);
    bus(1, `MASK_OFS, 32'h1C);
    {stream_error, chan3_frame_pulse, chan2_frame_pulse} <= 3'h7;
    repeat (6) @(posedge clock);
    ck("err_irq", 1, port_error_irq);
    ck("irq", 1, irq);
    rd(`STATUS_OFS, 32'h1C);
    ck("ch3_pulses", 1, c3_n);
    ck("ch2_pulses", 1, c2_n);
    {stream_error, chan3_frame_pulse, chan2_frame_pulse} <= 3'h0;
    repeat (6) @(posedge clock);
    bus(1, `STATUS_OFS, 32'h1C);
    @(posedge clock);
    ck("irq", 0, irq);
    rd(`DISARM_OFS, 0);
    rd(12'h100, 0);
    for (int b = 2; b < 5; b++) begin
      bus(1, `DISARM_OFS, 32'h1 << b);
      rd(`ARM_SET_OFS, 32'h1C & (32'hFFFFFFFF << (b + 1)));
    end
    repeat (2) @(posedge clock);
    conclude;
  end
endmodule
bind irq_arm_set_logic irq_arm_props irq_arm_props_i (.clock, .sys_rst,
  .psel, .penable, .pwrite, .pslverr, .paddr, .prdata, .stream_error,
  .chan3_frame_pulse, .chan2_frame_pulse, .port_error_irq,
  .chan3_frame_irq, .chan2_frame_irq);
